// ==== rtl/cmd_device.sv ====
// module end: command interpreter, settings store and pass-through fifo
// assumes a host end on cmd_link_if and a wireless peer on plain ports
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "cmd_defines.svh"

////////////////////////////////////////////////////////////////////////
module cmd_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp;
	logic [AW:0] rp;
	wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	wire empty = (wp == rp);
	wire push = i_in_valid && !full;
	wire pop = !empty && i_out_ready;
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rp[AW-1:0]];
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (push)
			mem[wp[AW-1:0]] <= i_in_data;
	end
endmodule : cmd_fifo

////////////////////////////////////////////////////////////////////////
// Functional notes
// - pass command forwards uart bytes to peer
// - boot switch toggle or reset leaves pass-through
// - pass command from peer ends pass-through
// - attribute write: handle, type 0/1, central only
// - host sends payload as hex digit pairs
// - set changes only volatile working values
// - reboot loads working values from store
// - host sends numbers as ascii hex
// - input eight high at boot restores defaults
// - query lists all or named setting
// - reports show unsaved working values
// - restore writes defaults, no save needed
// - set value persists only after save
// - live setting applies now, lost unsaved
// - save copies working values to store
// - analog boot flag, default off, reboot
// - version command returns version text
// - carriage return ends every command line
module cmd_device
	import cmd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	cmd_link_if.dev link,
	output logic o_peer_valid,
	output logic [7:0] o_peer_data,
	input wire logic i_peer_ready,
	input wire logic i_peer_valid,
	input wire logic [7:0] i_peer_data,
	input wire logic i_gpio_ctrl_en,
	input wire logic i_central,
	output logic o_attr_req,
	output logic [15:0] o_attr_handle,
	output logic o_attr_type,
	output logic [7:0] o_attr_data,
	output logic o_analog_boot_en,
	output logic o_auto_connect,
	output logic o_passthrough
);
	function automatic logic [4:0] hexv(input logic [7:0] c);
		hexv = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
			hexv = {1'b1, c[3:0]};
		else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
			hexv = {1'b1, 4'(c[3:0] + 4'h9)};
	endfunction : hexv

	function automatic logic [159:0] app(input logic [159:0] b,
		input int n, input logic [63:0] s, input int k);
		logic [159:0] t;
		t = {96'h0, s} >> (8 * (8 - k));
		app = b | (t << (8 * (`RESP_LEN - n - k)));
	endfunction : app

	dev_state_t st;
	byte_t line [`LINE_LEN];
	logic [4:0] idx;
	logic ovf;
	logic [2:0] sy [2];
	logic [1:0] pin_st;
	logic sw_prev;
	logic [15:0] cnt;
	logic strap_held;
	logic [23:0] peer_sh;
	logic ws_aboot;
	logic ws_autoc;
	logic ee_aboot;
	logic ee_autoc;
	logic [7:0] ee_sig;
	logic ee_good;
	logic [159:0] resp_buf;
	logic [4:0] resp_cnt;
	logic [159:0] next_resp;
	logic [4:0] next_len;

	////////////////////////////////////////////////////////////////////
	// outside pins: three flops, taken when 2nd and 3rd agree
	wire [1:0] pins = {link.general_input_eight, link.boot_switch};
	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				sy[g] <= 3'h0;
				pin_st[g] <= 1'b0;
			end else begin
				sy[g] <= {sy[g][1:0], pins[g]};
				if (sy[g][1] == sy[g][2])
					pin_st[g] <= sy[g][2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// line decode
	wire in_hs = link.h2d_valid && link.h2d_ready;
	wire line_end = in_hs && (st == ST_CMD) && (link.h2d_data == `CR);
	wire [23:0] w3 = {line[0], line[1], line[2]};
	wire [31:0] w4 = {w3, line[3]};
	wire [31:0] nm = {line[4], line[5], line[6], line[7]};
	wire nm_aboot = (nm == `TXT_NM_ABOOT);
	wire nm_autoc = (nm == `TXT_NM_AUTOC);
	wire nm_ok = nm_aboot || nm_autoc;
	wire short = !ovf && (idx == `LEN_SHORT);
	wire is_pass = short && (w3 == `TXT_PASS);
	wire is_vers = short && (w3 == `TXT_VERS);
	wire is_save = short && (w3 == `TXT_SAVE);
	wire is_rest = short && (w3 == `TXT_RESTORE);
	wire is_all = short && (w3 == `TXT_LIST || w3 == `TXT_QUERY);
	wire is_get1 = !ovf && (idx == `LEN_GET1) && (w3 == `TXT_QUERY)
		&& (line[3] == `SP) && nm_ok;
	wire val_on = (idx == `LEN_SET_ON) && ({line[9], line[10]} == `TXT_ON);
	wire val_off = (idx == `LEN_SET_OFF)
		&& ({line[9], line[10], line[11]} == `TXT_OFF);
	wire is_set = !ovf && (w3 == `TXT_SET) && (line[3] == `SP) && nm_ok
		&& (line[8] == `EQ) && (val_on || val_off);
	wire [4:0] h0 = hexv(line[5]);
	wire [4:0] h1 = hexv(line[6]);
	wire [4:0] h2 = hexv(line[7]);
	wire [4:0] h3 = hexv(line[8]);
	wire [4:0] d0 = hexv(line[12]);
	wire [4:0] d1 = hexv(line[13]);
	wire type_ok = (line[10] == 8'h30) || (line[10] == 8'h31);
	wire is_attrw = !ovf && (idx == `LEN_ATTRW) && (w4 == `TXT_ATTRW)
		&& (line[4] == `SP) && (line[9] == `SP) && (line[11] == `SP)
		&& h0[4] && h1[4] && h2[4] && h3[4] && d0[4] && d1[4]
		&& type_ok && i_central;
	wire show_aboot = is_all || (is_get1 && nm_aboot);
	wire show_autoc = is_all || (is_get1 && nm_autoc);
	wire is_ack = is_set || is_save || is_rest || is_attrw;
	wire do_set = line_end && is_set;
	wire do_save = line_end && is_save;
	wire do_rest = line_end && is_rest;
	wire boot_end = (st == ST_BOOT) && (cnt == 16'(`BOOT_HOLD_CYC - 1));
	wire sw_toggle = (pin_st[0] != sw_prev) && i_gpio_ctrl_en;
	wire peer_exit = i_peer_valid
		&& ({peer_sh, i_peer_data} == {`TXT_PASS, `CR});

	////////////////////////////////////////////////////////////////////
	// answer text, always from the working values
	always_comb begin
		int n;
		n = 0;
		next_resp = '0;
		if (show_aboot) begin
			next_resp = app(next_resp, n, {`TXT_NM_ABOOT, `EQ, 24'h0}, 5);
			n = n + 5;
			if (ws_aboot) begin
				next_resp = app(next_resp, n, {`TXT_ON, 48'h0}, 2);
				n = n + 2;
			end else begin
				next_resp = app(next_resp, n, {`TXT_OFF, 40'h0}, 3);
				n = n + 3;
			end
		end
		if (show_autoc) begin
			if (n != 0) begin
				next_resp = app(next_resp, n, {`SP, 56'h0}, 1);
				n = n + 1;
			end
			next_resp = app(next_resp, n, {`TXT_NM_AUTOC, `EQ, 24'h0}, 5);
			n = n + 5;
			if (ws_autoc) begin
				next_resp = app(next_resp, n, {`TXT_ON, 48'h0}, 2);
				n = n + 2;
			end else begin
				next_resp = app(next_resp, n, {`TXT_OFF, 40'h0}, 3);
				n = n + 3;
			end
		end
		if (st == ST_BOOT) begin
			next_resp = app(next_resp, n, {`TXT_WELCOME, 40'h0}, 3);
			n = n + 3;
		end else if (is_vers) begin
			next_resp = app(next_resp, n, {`TXT_VERSION, 32'h0}, 4);
			n = n + 4;
		end else if (is_ack) begin
			next_resp = app(next_resp, n, {`TXT_OK, 48'h0}, 2);
			n = n + 2;
		end else if (n == 0) begin
			next_resp = app(next_resp, n, {`TXT_ERR, 40'h0}, 3);
			n = n + 3;
		end
		next_resp = app(next_resp, n, {`CR, 56'h0}, 1);
		next_len = 5'(n + 1);
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			resp_buf <= '0;
			resp_cnt <= 5'h00;
		end else if (boot_end || (line_end && !is_pass)) begin
			resp_buf <= next_resp;
			resp_cnt <= next_len;
		end else if (link.d2h_valid && link.d2h_ready) begin
			resp_buf <= {resp_buf[151:0], 8'h00};
			resp_cnt <= resp_cnt - 5'h01;
		end
	end
	assign link.d2h_valid = (resp_cnt != 5'h00);
	assign link.d2h_data = resp_buf[159:152];

	////////////////////////////////////////////////////////////////////
	// line capture; overlong lines get an error
	always_ff @(posedge i_clk) begin
		if (in_hs && st == ST_CMD && !line_end && idx < 5'(`LINE_LEN))
			line[idx[3:0]] <= link.h2d_data;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idx <= 5'h00;
			ovf <= 1'b0;
		end else if (line_end || st != ST_CMD) begin
			idx <= 5'h00;
			ovf <= 1'b0;
		end else if (in_hs) begin
			if (idx < 5'(`LINE_LEN))
				idx <= idx + 5'h01;
			else
				ovf <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode, boot and working settings
	always_comb begin
		ee_good = 1'b0;
		if (ee_sig == `EE_SIG && !strap_held)
			ee_good = 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= ST_BOOT;
			cnt <= 16'h0000;
			strap_held <= 1'b1;
			sw_prev <= 1'b0;
			peer_sh <= 24'h0;
			ws_aboot <= `ABOOT_DEF;
			ws_autoc <= `AUTOC_DEF;
			o_analog_boot_en <= `ABOOT_DEF;
		end else begin
			sw_prev <= pin_st[0];
			if (i_peer_valid)
				peer_sh <= {peer_sh[15:0], i_peer_data};
			unique case (st)
				ST_BOOT: begin
					cnt <= cnt + 16'h0001;
					if (cnt >= `STRAP_SETTLE && !pin_st[1])
						strap_held <= 1'b0;
					if (boot_end) begin
						st <= ST_CMD;
						if (ee_good) begin
							ws_aboot <= ee_aboot;
							ws_autoc <= ee_autoc;
							o_analog_boot_en <= ee_aboot;
						end else begin
							ws_aboot <= `ABOOT_DEF;
							ws_autoc <= `AUTOC_DEF;
							o_analog_boot_en <= `ABOOT_DEF;
						end
					end
				end
				ST_CMD: begin
					if (line_end && is_pass)
						st <= ST_PASS;
					if (do_set && nm_aboot)
						ws_aboot <= val_on;
					if (do_set && nm_autoc)
						ws_autoc <= val_on;
					if (do_rest) begin
						ws_aboot <= `ABOOT_DEF;
						ws_autoc <= `AUTOC_DEF;
					end
				end
				ST_PASS: begin
					if (sw_toggle || peer_exit)
						st <= ST_CMD;
				end
				default: st <= ST_CMD;
			endcase
		end
	end

	// store survives reset; the marker says it holds data
	wire ee_wr = (boot_end && !ee_good) || do_save || do_rest;
	always_ff @(posedge i_clk) begin
		if (ee_wr) begin
			ee_sig <= `EE_SIG;
			ee_aboot <= do_save ? ws_aboot : `ABOOT_DEF;
			ee_autoc <= do_save ? ws_autoc : `AUTOC_DEF;
		end
	end

	////////////////////////////////////////////////////////////////////
	// attribute write request to the radio side
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_attr_req <= 1'b0;
			o_attr_handle <= 16'h0000;
			o_attr_type <= 1'b0;
			o_attr_data <= 8'h00;
		end else begin
			o_attr_req <= line_end && is_attrw;
			if (line_end && is_attrw) begin
				o_attr_handle <= {h0[3:0], h1[3:0], h2[3:0], h3[3:0]};
				o_attr_type <= line[10][0];
				o_attr_data <= {d0[3:0], d1[3:0]};
			end
		end
	end

	assign o_auto_connect = ws_autoc;
	assign o_passthrough = (st == ST_PASS);

	// fifo lets the host burst while the radio side stalls
	wire fifo_ready;
	assign link.h2d_ready = (st == ST_PASS) ? fifo_ready
		: ((st == ST_CMD) && (resp_cnt == 5'h00));
	cmd_fifo #(.W(`BYTE_W), .D(`FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_in_valid(link.h2d_valid && (st == ST_PASS)),
		.o_in_ready(fifo_ready),
		.i_in_data(link.h2d_data),
		.o_out_valid(o_peer_valid),
		.i_out_ready(i_peer_ready),
		.o_out_data(o_peer_data)
	);
endmodule : cmd_device

// ==== rtl/cmd_defines.svh ====
// constants of the command link: text codes, lengths, settings, timing
// assumes 8-bit ascii bytes on both streams and a 250 MHz clock
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

`define CR 8'h0d
`define SP 8'h20
`define EQ 8'h3d
`define LINE_LEN 16
`define RESP_LEN 20
`define FIFO_DEPTH 8
`define BYTE_W 8

`define TXT_PASS 24'h545253
`define TXT_VERS 24'h564552
`define TXT_SAVE 24'h575254
`define TXT_RESTORE 24'h525452
`define TXT_LIST 24'h434647
`define TXT_QUERY 24'h474554
`define TXT_SET 24'h534554
`define TXT_ATTRW 32'h57434852
`define TXT_NM_ABOOT 32'h41434647
`define TXT_NM_AUTOC 32'h41434f4e
`define TXT_ON 16'h4f4e
`define TXT_OFF 24'h4f4646
`define TXT_OK 16'h4f4b
`define TXT_ERR 24'h455252
`define TXT_WELCOME 24'h524459
// arbitrary version text
`define TXT_VERSION 32'h56312e30

`define LEN_SHORT 5'd3
`define LEN_GET1 5'd8
`define LEN_SET_ON 5'd11
`define LEN_SET_OFF 5'd12
`define LEN_ATTRW 5'd14

`define ABOOT_DEF 1'b0
`define AUTOC_DEF 1'b1
// arbitrary marker of a written store
`define EE_SIG 8'ha5

`define CLK_MHZ 250
`define BOOT_HOLD_US 1
`define BOOT_HOLD_CYC (`BOOT_HOLD_US * `CLK_MHZ)
`define STRAP_SETTLE 16'h0004

`define HOST_TX 8'h00
`define HOST_HEX 8'h04
`define HOST_RX 8'h08
`define HOST_CTRL 8'h0c
`define HOST_STAT 8'h10

`endif

// ==== rtl/cmd_pkg.sv ====
// types shared by the two ends of the command link
// assumes cmd_defines.svh for all numbers
package cmd_pkg;
	typedef enum logic [2:0] {
		ST_BOOT = 3'b001,
		ST_CMD = 3'b010,
		ST_PASS = 3'b100
	} dev_state_t;
	typedef logic [7:0] byte_t;
endpackage : cmd_pkg

// ==== rtl/cmd_link_if.sv ====
// link between host processor end and module end: two byte streams
// plus the two boot-time pins; all on the one system clock
`timescale 1ns/10ps
interface cmd_link_if;
	logic h2d_valid;
	logic [7:0] h2d_data;
	logic h2d_ready;
	logic d2h_valid;
	logic [7:0] d2h_data;
	logic d2h_ready;
	logic boot_switch;
	logic general_input_eight;
	modport dev(input h2d_valid, input h2d_data, output h2d_ready,
		output d2h_valid, output d2h_data, input d2h_ready,
		input boot_switch, input general_input_eight);
	modport host(output h2d_valid, output h2d_data, input h2d_ready,
		input d2h_valid, input d2h_data, output d2h_ready,
		output boot_switch, output general_input_eight);
endinterface : cmd_link_if

// ==== rtl/cmd_host.sv ====
// host end: apb slave that turns register writes into command bytes
// assumes an apb master on i_clk and a module end on cmd_link_if
`timescale 1ns/10ps
`include "cmd_defines.svh"

module cmd_host
	import cmd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	cmd_link_if.host link
);
	function automatic byte_t hexc(input logic [3:0] v);
		hexc = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction : hexc

	logic [1:0] tx_cnt;
	byte_t tx_b0;
	byte_t tx_b1;
	logic rx_full;
	byte_t rx_byte;
	logic ctrl_gie;
	logic ctrl_sw;

	////////////////////////////////////////////////////////////////////
	wire acc = i_psel && i_penable;
	wire sel_tx = (i_paddr == `HOST_TX);
	wire sel_hex = (i_paddr == `HOST_HEX);
	wire sel_rx = (i_paddr == `HOST_RX);
	wire sel_ctrl = (i_paddr == `HOST_CTRL);
	wire sel_stat = (i_paddr == `HOST_STAT);
	wire mapped = sel_tx || sel_hex || sel_rx || sel_ctrl || sel_stat;
	// byte writes wait while earlier bytes are queued
	wire stall = i_pwrite && (sel_tx || sel_hex) && (tx_cnt != 2'h0);
	wire done = acc && o_pready;
	wire tx_hs = link.h2d_valid && link.h2d_ready;
	wire rx_hs = link.d2h_valid && link.d2h_ready;
	wire [31:0] rd_val = sel_rx ? {23'h0, rx_full, rx_byte}
		: sel_ctrl ? {30'h0, ctrl_sw, ctrl_gie}
		: sel_stat ? {30'h0, rx_full, tx_cnt != 2'h0} : 32'h0;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0;
		end else begin
			o_pready <= acc && !o_pready && !stall;
			o_pslverr <= acc && !o_pready && !stall && !mapped;
			o_prdata <= (i_pwrite || !acc) ? 32'h0 : rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_cnt <= 2'h0;
			tx_b0 <= 8'h00;
			tx_b1 <= 8'h00;
		end else if (done && i_pwrite && sel_hex) begin
			tx_b0 <= hexc(i_pwdata[7:4]);
			tx_b1 <= hexc(i_pwdata[3:0]);
			tx_cnt <= 2'h2;
		end else if (done && i_pwrite && sel_tx) begin
			tx_b0 <= i_pwdata[7:0];
			tx_cnt <= 2'h1;
		end else if (tx_hs) begin
			tx_b0 <= tx_b1;
			tx_cnt <= tx_cnt - 2'h1;
		end
	end
	assign link.h2d_valid = (tx_cnt != 2'h0);
	assign link.h2d_data = tx_b0;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_full <= 1'b0;
			rx_byte <= 8'h00;
			ctrl_gie <= 1'b0;
			ctrl_sw <= 1'b0;
		end else begin
			if (done && !i_pwrite && sel_rx)
				rx_full <= 1'b0;
			if (rx_hs) begin
				rx_full <= 1'b1;
				rx_byte <= link.d2h_data;
			end
			if (done && i_pwrite && sel_ctrl) begin
				ctrl_gie <= i_pwdata[0];
				ctrl_sw <= i_pwdata[1];
			end
		end
	end
	// no byte lands during an rx read, else it is popped unseen
	assign link.d2h_ready = !rx_full && !(acc && sel_rx && !i_pwrite);
	assign link.general_input_eight = ctrl_gie;
	assign link.boot_switch = ctrl_sw;
endmodule : cmd_host

// ==== tb/cmd_link_monitor.sv ====
// checker of the link between the host end and the module end
// assumes the module end's clock, reset and plain link signals
`timescale 1ns/10ps
`include "cmd_defines.svh"

module cmd_link_monitor (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic h2d_valid,
	input wire logic [7:0] h2d_data,
	input wire logic h2d_ready,
	input wire logic d2h_valid,
	input wire logic [7:0] d2h_data,
	input wire logic d2h_ready
);
	localparam int QUIET = `BOOT_HOLD_CYC - 2;
	logic [8:0] age;
	logic [23:0] last3;
	logic said;
	logic pass_mode;
	// peer exit unseen here: pass mode clears at reset only
	wire acc = h2d_valid && h2d_ready;
	wire cr_acc = acc && h2d_data == `CR && !pass_mode;
	wire is_pass = last3 == `TXT_PASS;
	wire [8:0] next_age = (age == 9'h1ff) ? age : age + 9'h001;
	wire [23:0] next_last3 = (h2d_data == `CR) ? 24'h0 : {last3[15:0], h2d_data};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			age <= 9'h000;
			last3 <= 24'h000000;
			said <= 1'b0;
			pass_mode <= 1'b0;
		end else begin
			age <= next_age;
			if (acc)
				last3 <= next_last3;
			said <= said | d2h_valid;
			pass_mode <= pass_mode | (cr_acc && is_pass);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking mon_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_last_byte;
		d2h_valid && d2h_ready ##1 !d2h_valid;
	endsequence
	sequence s_pass_end;
		cr_acc && is_pass;
	endsequence
	sequence s_ver_end;
		cr_acc && last3 == `TXT_VERS;
	endsequence

	property p_boot_quiet;
		age < QUIET |-> !h2d_ready;
	endproperty
	a_boot_quiet: assert property (p_boot_quiet)
		else $error("link ready during boot");
	property p_welcome;
		d2h_valid && !said |-> d2h_data == 8'(`TXT_WELCOME >> 16);
	endproperty
	a_welcome: assert property (p_welcome)
		else $error("no welcome");
	property p_d2h_hold;
		d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
	endproperty
	a_d2h_hold: assert property (p_d2h_hold)
		else $error("answer byte dropped");
	property p_h2d_hold;
		h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
	endproperty
	a_h2d_hold: assert property (p_h2d_hold)
		else $error("command byte dropped");
	property p_line_end;
		s_last_byte |-> $past(d2h_data) == `CR;
	endproperty
	a_line_end: assert property (p_line_end)
		else $error("answer not closed");
	property p_answer;
		cr_acc && !is_pass |=> d2h_valid;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no answer");
	property p_stall;
		!pass_mode && d2h_valid |-> !h2d_ready;
	endproperty
	a_stall: assert property (p_stall)
		else $error("byte taken during answer");
	property p_pass_silent;
		s_pass_end |=> !d2h_valid [*3];
	endproperty
	a_pass_silent: assert property (p_pass_silent)
		else $error("answer on pass entry");
	property p_version;
		s_ver_end |=> d2h_valid && d2h_data == 8'(`TXT_VERSION >> 24);
	endproperty
	a_version: assert property (p_version)
		else $error("bad version answer");
endmodule : cmd_link_monitor

// ==== tb/ble_module_uart_command_config_bench.sv ====
// bench: apb master on the host end, radio peer on the module end
// assumes both ends and the link interface from the rtl folder
`timescale 1ns/10ps
`include "cmd_defines.svh"

module ble_module_uart_command_config_bench;
	localparam logic [159:0] OK_R = {`TXT_OK, `CR};
	logic clk = 1'b0, host_resetn = 1'b0, dev_resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00, peer_data = 8'h00, peer_out_data, attr_data;
	logic [31:0] pwdata = 32'h0, prdata;
	logic peer_ready = 1'b0, peer_valid = 1'b0, gpio_en = 1'b0;
	logic central = 1'b1, peer_out_valid, attr_req, attr_type;
	logic aboot, autoc, passthru;
	logic [15:0] attr_handle;
	int miscompares = 0, checks_done = 0, n_attr = 0;
	logic [7:0] rx_q[$];

	always #2 clk = ~clk;

	cmd_link_if cmd_link_if_inst ();
	cmd_host cmd_host_inst (.i_clk(clk), .i_resetn(host_resetn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .link(cmd_link_if_inst));
	cmd_device cmd_device_inst (.i_clk(clk), .i_resetn(dev_resetn),
		.link(cmd_link_if_inst), .o_peer_valid(peer_out_valid),
		.o_peer_data(peer_out_data), .i_peer_ready(peer_ready),
		.i_peer_valid(peer_valid), .i_peer_data(peer_data),
		.i_gpio_ctrl_en(gpio_en), .i_central(central),
		.o_attr_req(attr_req), .o_attr_handle(attr_handle),
		.o_attr_type(attr_type), .o_attr_data(attr_data),
		.o_analog_boot_en(aboot), .o_auto_connect(autoc),
		.o_passthrough(passthru));
	cmd_link_monitor cmd_link_monitor_inst (.i_clk(clk),
		.i_resetn(dev_resetn), .h2d_valid(cmd_link_if_inst.h2d_valid),
		.h2d_data(cmd_link_if_inst.h2d_data),
		.h2d_ready(cmd_link_if_inst.h2d_ready),
		.d2h_valid(cmd_link_if_inst.d2h_valid),
		.d2h_data(cmd_link_if_inst.d2h_data),
		.d2h_ready(cmd_link_if_inst.d2h_ready));

	always @(posedge clk) begin
		if (peer_out_valid && peer_ready)
			rx_q.push_back(peer_out_data);
		if (attr_req)
			n_attr++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic give_up(input string what);
		$display("ERROR %s expected done seen timeout", what);
		miscompares++;
		complete_run();
	endtask : give_up

	task automatic check(input logic [159:0] exp, got, input string what);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 4000);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) give_up("pready");
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask : wr

	task automatic send(input logic [127:0] t, input int n);
		for (int i = n - 1; i >= 0; i--)
			wr(`HOST_TX, t[8*i +: 8]);
		wr(`HOST_TX, `CR);
	endtask : send

	// polls rx; empty reads carry no byte
	task automatic expect_resp(input logic [159:0] exp, input string what);
		logic [159:0] got;
		logic [31:0] q;
		logic e;
		int n;
		got = '0;
		n = 0;
		do begin
			apb(1'b0, `HOST_RX, 32'h0, q, e);
			if (q[8])
				got = {got[151:0], q[7:0]};
			n++;
		end while (!(q[8] && q[7:0] == `CR) && n < 2000);
		check(exp, got, what);
		if (n >= 2000) give_up(what);
	endtask : expect_resp

	// only the module end reboots; host pins keep their level
	task automatic reboot();
		dev_resetn <= 1'b0;
		repeat (8) @(posedge clk);
		dev_resetn <= 1'b1;
		expect_resp({`TXT_WELCOME, `CR}, "welcome");
	endtask : reboot

	task automatic set_opt(input logic [31:0] nm, input logic v);
		if (v)
			send({`TXT_SET, `SP, nm, `EQ, `TXT_ON}, `LEN_SET_ON);
		else
			send({`TXT_SET, `SP, nm, `EQ, `TXT_OFF}, `LEN_SET_OFF);
		expect_resp(OK_R, "set");
	endtask : set_opt

	function automatic logic [159:0] word(input logic [159:0] s, input logic v);
		word = v ? {s[143:0], `TXT_ON} : {s[135:0], `TXT_OFF};
	endfunction : word

	function automatic logic [159:0] cfg_all(input logic a, input logic c);
		logic [159:0] s;
		s = word(160'({`TXT_NM_ABOOT, `EQ}), a);
		s = word({s[111:0], `SP, `TXT_NM_AUTOC, `EQ}, c);
		cfg_all = {s[151:0], `CR};
	endfunction : cfg_all

	task automatic wait_pass(input logic v, input string what);
		int n;
		for (n = 0; n < 50 && passthru !== v; n++)
			@(posedge clk);
		check(v, passthru, what);
		if (n == 50) give_up(what);
	endtask : wait_pass

	task automatic attr(input logic t);
		logic [31:0] w;
		int n0;
		n0 = n_attr;
		w = `TXT_ATTRW;
		for (int i = 3; i >= 0; i--)
			wr(`HOST_TX, w[8*i +: 8]);
		wr(`HOST_TX, `SP);
		wr(`HOST_HEX, 8'h01);
		wr(`HOST_HEX, 8'ha2);
		wr(`HOST_TX, `SP);
		wr(`HOST_TX, {7'h18, t});
		wr(`HOST_TX, `SP);
		wr(`HOST_HEX, 8'h5c);
		wr(`HOST_TX, `CR);
		expect_resp(central ? OK_R : {`TXT_ERR, `CR}, "attr");
		check(central ? n0 + 1 : n0, n_attr, "attr pulses");
		check({16'h01a2, t, 8'h5c}, {attr_handle, attr_type, attr_data},
			"attr fields");
	endtask : attr

	// peer stalls till fifo refuses, then drains
	task automatic pass_fill();
		int n;
		gpio_en <= 1'b1;
		send(`TXT_PASS, 3);
		wait_pass(1'b1, "enter");
		for (int i = 0; i < 9; i++)
			wr(`HOST_TX, 8'(8'h40 + i));
		repeat (4) @(posedge clk);
		check(2'b10, {cmd_link_if_inst.h2d_valid,
			cmd_link_if_inst.h2d_ready}, "fifo full");
		peer_ready <= 1'b1;
		for (n = 0; n < 100 && rx_q.size() < 9; n++)
			@(posedge clk);
		for (int i = 0; i < 9; i++)
			check(8'(8'h40 + i), rx_q[i], "peer byte");
		@(posedge clk);
		check(1'b0, peer_out_valid, "drained");
		wr(`HOST_CTRL, 8'h02);
		wait_pass(1'b0, "switch exit");
		if (n == 100) give_up("drain");
	endtask : pass_fill

	task automatic pass_peer();
		logic [31:0] w;
		w = {`TXT_PASS, `CR};
		gpio_en <= 1'b0;
		send(`TXT_PASS, 3);
		wait_pass(1'b1, "enter");
		wr(`HOST_CTRL, 8'h00);
		repeat (20) @(posedge clk);
		check(1'b1, passthru, "switch ignored");
		for (int i = 3; i >= 0; i--) begin
			@(posedge clk);
			peer_valid <= 1'b1;
			peer_data <= w[8*i +: 8];
		end
		@(posedge clk);
		peer_valid <= 1'b0;
		wait_pass(1'b0, "peer exit");
	endtask : pass_peer

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		logic e;
		repeat (3) @(posedge clk);
		host_resetn <= 1'b1;
		dev_resetn <= 1'b1;
		expect_resp({`TXT_WELCOME, `CR}, "welcome");
		check(2'b01, {aboot, autoc}, "boot flags");
		apb(1'b0, 8'h20, 32'h0, q, e);
		check({1'b1, 32'h0}, {e, q}, "unmapped");
		send(`TXT_VERS, 3);
		expect_resp({`TXT_VERSION, `CR}, "version");
		send(`TXT_LIST, 3);
		expect_resp(cfg_all(1'b0, 1'b1), "list");
		send(`TXT_QUERY, 3);
		expect_resp(cfg_all(1'b0, 1'b1), "query");
		send(24'h58595a, 3);
		expect_resp({`TXT_ERR, `CR}, "unknown");
		check(1'b1, autoc, "unchanged");
		set_opt(`TXT_NM_AUTOC, 1'b0);
		check(1'b0, autoc, "live");
		send({`TXT_QUERY, `SP, `TXT_NM_AUTOC}, `LEN_GET1);
		expect_resp({`TXT_NM_AUTOC, `EQ, `TXT_OFF, `CR}, "one");
		set_opt(`TXT_NM_ABOOT, 1'b1);
		check(1'b0, aboot, "not yet");
		send(`TXT_LIST, 3);
		expect_resp(cfg_all(1'b1, 1'b0), "unsaved");
		reboot();
		check(2'b01, {aboot, autoc}, "lost");
		set_opt(`TXT_NM_ABOOT, 1'b1);
		set_opt(`TXT_NM_AUTOC, 1'b0);
		send(`TXT_SAVE, 3);
		expect_resp(OK_R, "save");
		reboot();
		check(2'b10, {aboot, autoc}, "kept");
		send(`TXT_RESTORE, 3);
		expect_resp(OK_R, "restore");
		send(`TXT_LIST, 3);
		expect_resp(cfg_all(1'b0, 1'b1), "defaults");
		check(1'b1, aboot, "restore waits");
		reboot();
		check(2'b01, {aboot, autoc}, "restored");
		set_opt(`TXT_NM_AUTOC, 1'b0);
		send(`TXT_SAVE, 3);
		expect_resp(OK_R, "save");
		wr(`HOST_CTRL, 8'h01);
		reboot();
		wr(`HOST_CTRL, 8'h00);
		check(1'b1, autoc, "strap");
		reboot();
		check(1'b1, autoc, "strap stored");
		attr(1'b0);
		attr(1'b1);
		central <= 1'b0;
		attr(1'b1);
		pass_fill();
		pass_peer();
		send(`TXT_PASS, 3);
		wait_pass(1'b1, "enter");
		reboot();
		check(1'b0, passthru, "reset exit");
		complete_run();
	end

	initial begin
		#300000;
		give_up("watchdog");
	end
endmodule : ble_module_uart_command_config_bench
